// File: core/sfp_pkg.sv
package sfp_pkg;

  // ==========================================================================
  // Structure
  localparam int NUM_OUT     = 2;
  localparam int LOW_SEL_W   = 3;
  localparam int HIGH_SEL_W  = 1;
  localparam int BLANK_SEL_W = 2;
  localparam int BLANK_CNT_W = 12;

  // ==========================================================================
  // Reset values of the overcurrent settings
  localparam logic [LOW_SEL_W-1:0]   LOW_SEL_RST   = 3'h0;
  localparam logic [HIGH_SEL_W-1:0]  HIGH_SEL_RST  = 1'h0;
  localparam logic [BLANK_SEL_W-1:0] BLANK_SEL_RST = 2'h0;

  // ==========================================================================
  // Blanking times, in microseconds, and their cycle counts at 50 MHz
  localparam int CLK_MHZ     = 50;
  localparam int BLANK_T0_US = 10;
  localparam int BLANK_T1_US = 20;
  localparam int BLANK_T2_US = 40;
  localparam int BLANK_T3_US = 80;
  localparam logic [BLANK_CNT_W-1:0] BLANK_CYC0 = BLANK_CNT_W'(BLANK_T0_US * CLK_MHZ);
  localparam logic [BLANK_CNT_W-1:0] BLANK_CYC1 = BLANK_CNT_W'(BLANK_T1_US * CLK_MHZ);
  localparam logic [BLANK_CNT_W-1:0] BLANK_CYC2 = BLANK_CNT_W'(BLANK_T2_US * CLK_MHZ);
  localparam logic [BLANK_CNT_W-1:0] BLANK_CYC3 = BLANK_CNT_W'(BLANK_T3_US * CLK_MHZ);

  // ==========================================================================
  // Status word positions
  localparam int STATUS_W       = 6;
  localparam int ST_UNDERVOLT   = 0;
  localparam int ST_BIT_ONE     = 1;
  localparam int ST_THERMAL     = 2;
  localparam int ST_OPEN_LOAD   = 3;
  localparam int ST_OC_LOW      = 4;
  localparam int ST_OC_HIGH     = 5;

  // ==========================================================================
  // Synchroniser vector layout
  localparam int AS_SUPPLY_OK = 0;
  localparam int AS_OVERVOLT  = 1;
  localparam int AS_UNDERVOLT = 2;
  localparam int AS_BELOW_MIN = 3;
  localparam int AS_OVERTEMP  = 4;
  localparam int AS_OPEN_LOAD = AS_OVERTEMP + NUM_OUT;
  localparam int AS_GATE_LOW  = AS_OPEN_LOAD + NUM_OUT;
  localparam int AS_CUR_LOW   = AS_GATE_LOW + NUM_OUT;
  localparam int AS_CUR_HIGH  = AS_CUR_LOW + NUM_OUT;
  localparam int AS_DIRECT    = AS_CUR_HIGH + NUM_OUT;
  localparam int ASYNC_W      = AS_DIRECT + NUM_OUT;

endpackage : sfp_pkg

// File: core/sfp_switch_fault_protection.sv
// Function
// - Logic supply loss resets all registers; direct inputs still drive outputs.
// - Without logic supply, protections keep running on default settings.
// - Fault flag goes low on thermal, open load, overcurrent, over or undervoltage.
// - Flag releases itself when fault clears, except overcurrent and latched undervoltage.
// - Fault bits held until a valid transfer returns them, then cleared.
// - Thermal detection only while that output is on.
// - Thermal fault holds output off until cool, then retries until commanded off.
// - Thermal event sets thermal bit, cleared by read or power reset.
// - Overvoltage holds outputs off and sets status bit one until read.
// - Overvoltage disable suppresses both shutdown and reporting.
// - Undervoltage turns outputs off, pulls flag low, sets undervoltage bit.
// - Recovery with command low releases flag; undervoltage bit stays until read.
// - Recovery with command on keeps output off and flag low until toggled.
// - Undervoltage disable hides it; output off only below minimum supply.
// - Open load checked only while off, latched once gate is low.
// - Open load bit clears on read only if the condition is gone.
// - Eight low and two high thresholds, both monitored together.
// - Low overcurrent beyond blanking time latches the output off.
// - High overcurrent latches the output off at once.
// - After overcurrent latch, output stays off until commanded off then on.
// - Output command is direct input or the serial output-on bit.
// - Fail-safe entry restores threshold and blanking defaults, keeps everything else.
`timescale 1ns/1ps
`default_nettype none

module sfp_switch_fault_protection (
  // Clock and reset
  input  wire logic                                                  sys_clk,
  input  wire logic                                                  arst_n,
  // Analog comparators and pins, asynchronous
  input  wire logic                                                  logic_supply_ok,
  input  wire logic                                                  supply_overvoltage,
  input  wire logic                                                  supply_undervoltage,
  input  wire logic                                                  supply_below_min,
  input  wire logic [sfp_pkg::NUM_OUT-1:0]                           over_temperature,
  input  wire logic [sfp_pkg::NUM_OUT-1:0]                           open_load_detect,
  input  wire logic [sfp_pkg::NUM_OUT-1:0]                           gate_low,
  input  wire logic [sfp_pkg::NUM_OUT-1:0]                           current_above_low,
  input  wire logic [sfp_pkg::NUM_OUT-1:0]                           current_above_high,
  input  wire logic [sfp_pkg::NUM_OUT-1:0]                           direct_output_inputs,
  // Serial interface decode, same clock
  input  wire logic                                                  cfg_write,
  input  wire logic                                                  cfg_sel,
  input  wire logic                                                  cfg_output_on,
  input  wire logic [sfp_pkg::LOW_SEL_W-1:0]                         cfg_low_sel,
  input  wire logic [sfp_pkg::HIGH_SEL_W-1:0]                        cfg_high_sel,
  input  wire logic [sfp_pkg::BLANK_SEL_W-1:0]                       cfg_blank_sel,
  input  wire logic                                                  cfg_overvoltage_disable,
  input  wire logic                                                  cfg_undervoltage_disable,
  input  wire logic                                                  cfg_open_load_disable,
  input  wire logic                                                  status_read,
  input  wire logic                                                  status_sel,
  input  wire logic                                                  fail_safe_entry,
  // Power stage and threshold selection
  output logic      [sfp_pkg::NUM_OUT-1:0]                           output_drive,
  output logic      [sfp_pkg::NUM_OUT-1:0][sfp_pkg::LOW_SEL_W-1:0]   low_overcurrent_threshold,
  output logic      [sfp_pkg::NUM_OUT-1:0][sfp_pkg::HIGH_SEL_W-1:0]  high_overcurrent_threshold,
  // Fault reporting
  output logic                                                       fault_flag_n,
  output logic      [sfp_pkg::STATUS_W-1:0]                          status_word,
  output logic      [sfp_pkg::NUM_OUT-1:0]                           thermal_fault_bit,
  output logic      [sfp_pkg::NUM_OUT-1:0]                           open_load_fault_bit,
  output logic                                                       overvoltage_fault_bit,
  output logic                                                       undervoltage_fault_bit
);

  localparam int N = sfp_pkg::NUM_OUT;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [sfp_pkg::ASYNC_W-1:0]                   sync1;
    logic [sfp_pkg::ASYNC_W-1:0]                   sync2;
    logic [N-1:0]                                  spi_on;
    logic                                          overvoltage_disable;
    logic                                          undervoltage_disable;
    logic                                          open_load_disable;
    logic [N-1:0][sfp_pkg::LOW_SEL_W-1:0]          low_sel;
    logic [N-1:0][sfp_pkg::HIGH_SEL_W-1:0]         high_sel;
    logic [N-1:0][sfp_pkg::BLANK_SEL_W-1:0]        blank_sel;
    logic [N-1:0][sfp_pkg::BLANK_CNT_W-1:0]        oc_cnt;
    logic [N-1:0]                                  oc_latch;
    logic [N-1:0]                                  ot_hold;
    logic [N-1:0]                                  uv_lock;
    logic [N-1:0]                                  drive;
    logic [N-1:0]                                  ot_bit;
    logic [N-1:0]                                  ol_bit;
    logic [N-1:0]                                  ocl_bit;
    logic [N-1:0]                                  och_bit;
    logic                                          ov_bit;
    logic                                          uv_bit;
    logic [sfp_pkg::STATUS_W-1:0]                  snap;
    logic                                          flag_n;
  } sfp_state_t;

  sfp_state_t q;
  sfp_state_t d;

  function automatic logic [sfp_pkg::BLANK_CNT_W-1:0] blank_cycles(
    input logic [sfp_pkg::BLANK_SEL_W-1:0] sel
  );
    case (sel)
      2'h0:    blank_cycles = sfp_pkg::BLANK_CYC0;
      2'h1:    blank_cycles = sfp_pkg::BLANK_CYC1;
      2'h2:    blank_cycles = sfp_pkg::BLANK_CYC2;
      default: blank_cycles = sfp_pkg::BLANK_CYC3;
    endcase
  endfunction : blank_cycles

  // ==========================================================================
  // Synchronised inputs
  logic [sfp_pkg::ASYNC_W-1:0] async_in;
  logic                        sup_ok_s;
  logic                        ov_s;
  logic                        uv_s;
  logic                        below_s;
  logic [N-1:0]                ot_s;
  logic [N-1:0]                ol_s;
  logic [N-1:0]                gate_low_s;
  logic [N-1:0]                cur_low_s;
  logic [N-1:0]                cur_high_s;
  logic [N-1:0]                direct_s;
  logic [N-1:0]                cmd;
  logic                        ov_now;
  logic                        uv_now;
  logic                        uv_off;
  logic [N-1:0]                ol_cond;

  assign async_in = {direct_output_inputs, current_above_high, current_above_low, gate_low,
                     open_load_detect, over_temperature, supply_below_min, supply_undervoltage,
                     supply_overvoltage, logic_supply_ok};
  assign sup_ok_s   = q.sync2[sfp_pkg::AS_SUPPLY_OK];
  assign ov_s       = q.sync2[sfp_pkg::AS_OVERVOLT];
  assign uv_s       = q.sync2[sfp_pkg::AS_UNDERVOLT];
  assign below_s    = q.sync2[sfp_pkg::AS_BELOW_MIN];
  assign ot_s       = q.sync2[sfp_pkg::AS_OVERTEMP +: N];
  assign ol_s       = q.sync2[sfp_pkg::AS_OPEN_LOAD +: N];
  assign gate_low_s = q.sync2[sfp_pkg::AS_GATE_LOW +: N];
  assign cur_low_s  = q.sync2[sfp_pkg::AS_CUR_LOW +: N];
  assign cur_high_s = q.sync2[sfp_pkg::AS_CUR_HIGH +: N];
  assign direct_s   = q.sync2[sfp_pkg::AS_DIRECT +: N];

  assign cmd     = direct_s | q.spi_on;
  assign ov_now  = ov_s & ~q.overvoltage_disable;
  assign uv_now  = uv_s & ~q.undervoltage_disable;
  assign uv_off  = q.undervoltage_disable ? below_s : uv_now;
  assign ol_cond = ol_s & gate_low_s & ~q.drive & {N{~q.open_load_disable}};

  // ==========================================================================
  // Next state
  always_comb begin
    logic clr;
    logic any_fault;
    clr       = 1'b0;
    any_fault = ov_now | uv_now;
    d         = q;
    d.sync1   = async_in;
    d.sync2   = q.sync1;

    if (status_read) begin
      d.snap                        = '0;
      d.snap[sfp_pkg::ST_UNDERVOLT] = q.uv_bit;
      d.snap[sfp_pkg::ST_BIT_ONE]   = q.ov_bit;
      d.snap[sfp_pkg::ST_THERMAL]   = q.ot_bit[status_sel];
      d.snap[sfp_pkg::ST_OPEN_LOAD] = q.ol_bit[status_sel];
      d.snap[sfp_pkg::ST_OC_LOW]    = q.ocl_bit[status_sel];
      d.snap[sfp_pkg::ST_OC_HIGH]   = q.och_bit[status_sel];
    end

    // Each output supervised on its own
    for (int i = 0; i < N; i++) begin
      clr = status_read && (status_sel == 1'(i));
      // Thermal hold only starts while driven, retries after cooling
      if (!cmd[i] || !ot_s[i]) begin
        d.ot_hold[i] = 1'b0;
      end else if (q.drive[i]) begin
        d.ot_hold[i] = 1'b1;
      end
      // Overcurrent latch released only by dropping the command
      if (!cmd[i]) begin
        d.oc_latch[i] = 1'b0;
        d.oc_cnt[i]   = '0;
      end else begin
        if (cur_low_s[i] && q.drive[i]) begin
          if (q.oc_cnt[i] >= blank_cycles(q.blank_sel[i])) begin
            d.oc_latch[i] = 1'b1;
          end else begin
            d.oc_cnt[i] = q.oc_cnt[i] + 1'b1;
          end
        end else begin
          d.oc_cnt[i] = '0;
        end
        if (cur_high_s[i] && q.drive[i]) begin
          d.oc_latch[i] = 1'b1;
        end
      end
      // Undervoltage while commanded on latches until toggled
      if (!cmd[i]) begin
        d.uv_lock[i] = 1'b0;
      end else if (uv_now) begin
        d.uv_lock[i] = 1'b1;
      end
      // Same-cycle high current cuts the drive without waiting for the latch
      d.drive[i] = cmd[i] & ~d.oc_latch[i] & ~d.ot_hold[i] & ~ov_now & ~uv_off
                   & ~d.uv_lock[i] & ~(cur_high_s[i] & q.drive[i]);
      // Sticky bits: a set in the clearing cycle wins
      d.ot_bit[i]  = (q.ot_bit[i] & ~clr) | (ot_s[i] & q.drive[i]);
      d.ol_bit[i]  = (q.ol_bit[i] & ~(clr & ~ol_cond[i])) | ol_cond[i];
      d.ocl_bit[i] = (q.ocl_bit[i] & ~clr) | (d.oc_latch[i] & ~q.oc_latch[i]
                     & ~(cur_high_s[i] & q.drive[i]));
      d.och_bit[i] = (q.och_bit[i] & ~clr) | (cur_high_s[i] & q.drive[i] & cmd[i]);
      any_fault = any_fault | q.ot_hold[i] | ol_cond[i] | q.oc_latch[i] | q.uv_lock[i];
    end

    d.ov_bit = (q.ov_bit & ~status_read) | ov_now;
    d.uv_bit = (q.uv_bit & ~status_read) | uv_now;
    d.flag_n = ~any_fault;

    if (cfg_write) begin
      d.spi_on[cfg_sel]    = cfg_output_on;
      d.low_sel[cfg_sel]   = cfg_low_sel;
      d.high_sel[cfg_sel]  = cfg_high_sel;
      d.blank_sel[cfg_sel] = cfg_blank_sel;
      d.overvoltage_disable             = cfg_overvoltage_disable;
      d.undervoltage_disable             = cfg_undervoltage_disable;
      d.open_load_disable             = cfg_open_load_disable;
    end
    // Fail-safe only touches overcurrent settings, so it wins over a write
    if (fail_safe_entry) begin
      d.low_sel   = {N{sfp_pkg::LOW_SEL_RST}};
      d.high_sel  = {N{sfp_pkg::HIGH_SEL_RST}};
      d.blank_sel = {N{sfp_pkg::BLANK_SEL_RST}};
    end
    // Logic supply gone: registers to defaults, protection state keeps running
    if (!sup_ok_s) begin
      d.spi_on    = '0;
      d.overvoltage_disable    = 1'b0;
      d.undervoltage_disable    = 1'b0;
      d.open_load_disable    = 1'b0;
      d.low_sel   = {N{sfp_pkg::LOW_SEL_RST}};
      d.high_sel  = {N{sfp_pkg::HIGH_SEL_RST}};
      d.blank_sel = {N{sfp_pkg::BLANK_SEL_RST}};
      d.ot_bit    = '0;
      d.ol_bit    = '0;
      d.ocl_bit   = '0;
      d.och_bit   = '0;
      d.ov_bit    = 1'b0;
      d.uv_bit    = 1'b0;
      d.snap      = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q        <= '0;
      q.flag_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  assign output_drive               = q.drive;
  assign low_overcurrent_threshold  = q.low_sel;
  assign high_overcurrent_threshold = q.high_sel;
  assign fault_flag_n               = q.flag_n;
  assign status_word                = q.snap;
  assign thermal_fault_bit          = q.ot_bit;
  assign open_load_fault_bit        = q.ol_bit;
  assign overvoltage_fault_bit      = q.ov_bit;
  assign undervoltage_fault_bit     = q.uv_bit;

  // ==========================================================================
  // Checks
  a_supply_loss_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !sup_ok_s |=> (q.spi_on == '0) && !q.overvoltage_disable && !q.uv_bit)
    else $error("registers not reset on logic supply loss");
  a_ov_flag_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ov_now |=> !fault_flag_n && (output_drive == '0))
    else $error("overvoltage did not pull flag low and cut outputs");
  a_ot_only_on: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(q.ot_hold[1]) |-> $past(q.drive[1]))
    else $error("thermal hold started on an idle output");
  a_read_clears_ov: assert property (@(posedge sys_clk) disable iff (!arst_n)
    status_read && q.ov_bit && !ov_now |=> !overvoltage_fault_bit
      && status_word[sfp_pkg::ST_BIT_ONE])
    else $error("overvoltage bit not returned then cleared by read");
  a_ov_disabled: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.overvoltage_disable && !q.ov_bit && !cfg_write |=> !overvoltage_fault_bit)
    else $error("disabled overvoltage still reported");
  a_undervoltage_disable_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.undervoltage_disable && !q.uv_bit && !cfg_write |=> !undervoltage_fault_bit)
    else $error("disabled undervoltage still reported");
  a_och_cuts_out: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cur_high_s[1] && q.drive[1] |=> !output_drive[1] ##1 !fault_flag_n)
    else $error("high overcurrent did not cut the output at once");
  a_oc_needs_toggle: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.oc_latch[0] && cmd[0] |=> !output_drive[0] && q.oc_latch[0])
    else $error("overcurrent latch released without command toggle");
  a_uv_lock_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.uv_lock[1] && cmd[1] |=> !output_drive[1] && !fault_flag_n)
    else $error("latched undervoltage released while still commanded");
  a_failsafe_dflt: assert property (@(posedge sys_clk) disable iff (!arst_n)
    fail_safe_entry |=> (q.blank_sel == {N{sfp_pkg::BLANK_SEL_RST}})
      && (q.low_sel == {N{sfp_pkg::LOW_SEL_RST}}) && (q.high_sel == {N{sfp_pkg::HIGH_SEL_RST}})
      && ($past(cfg_write) || !$past(sup_ok_s)
          || ((q.open_load_disable == $past(q.open_load_disable)) && (q.spi_on == $past(q.spi_on)))))
    else $error("fail-safe entry did not restore overcurrent defaults");

endmodule : sfp_switch_fault_protection

`default_nettype wire

// File: sim/sfp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sfp_host_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Commands from the bench
  input  wire logic [1:0] want_on,
  input  wire logic [1:0] reissue,
  // Direct pins toward the switch
  output logic      [1:0] direct_output_inputs
);

  // ==========================================================================
  // Direct command pins
  // A reissue drops the pin for one cycle, which is enough to clear a latch
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      direct_output_inputs <= 2'h0;
    end else begin
      direct_output_inputs <= want_on & ~reissue;
    end
  end

endmodule : sfp_host_model

`default_nettype wire

// File: sim/tb_sfp_switch_fault_protection.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_sfp_switch_fault_protection;
  logic            sys_clk = 1'b0;
  logic            arst_n = 1'b0;
  logic            spo = 1'b1, ov = 1'b0, uv = 1'b0, bm = 1'b0;
  logic      [1:0] ot = 2'h0, ol = 2'h0, gl = 2'h0, cl = 2'h0, ch = 2'h0, want = 2'h0, reiss = 2'h0, din;
  logic            cw = 1'b0, cs = 1'b0, con = 1'b0, ovd = 1'b0, uvd = 1'b0, old = 1'b0;
  logic            sr = 1'b0, ss = 1'b0, fse = 1'b0;
  logic            hsel = 1'b0;
  logic      [1:0] bsel = 2'h0;
  logic      [2:0] lsel = 3'h0;
  logic      [1:0] drv, tfb, olb;
  logic [1:0][2:0] lthr;
  logic [1:0][0:0] hthr;
  logic      [5:0] sw;
  logic            flag_n, ovb, uvb;
  int              err_total = 0;
  int              samples_checked = 0;

  always #10 sys_clk = ~sys_clk;

  sfp_host_model host (.sys_clk(sys_clk), .arst_n(arst_n), .want_on(want), .reissue(reiss),
    .direct_output_inputs(din));

  // High threshold and blanking codes move only in the blanking_code scenario
  sfp_switch_fault_protection DUT (.sys_clk(sys_clk), .arst_n(arst_n), .logic_supply_ok(spo),
    .supply_overvoltage(ov), .supply_undervoltage(uv), .supply_below_min(bm), .over_temperature(ot),
    .open_load_detect(ol), .gate_low(gl), .current_above_low(cl), .current_above_high(ch),
    .direct_output_inputs(din), .cfg_write(cw), .cfg_sel(cs), .cfg_output_on(con), .cfg_low_sel(lsel),
    .cfg_high_sel(hsel), .cfg_blank_sel(bsel), .cfg_overvoltage_disable(ovd),
    .cfg_undervoltage_disable(uvd), .cfg_open_load_disable(old), .status_read(sr), .status_sel(ss),
    .fail_safe_entry(fse), .output_drive(drv), .low_overcurrent_threshold(lthr),
    .high_overcurrent_threshold(hthr), .fault_flag_n(flag_n), .status_word(sw), .thermal_fault_bit(tfb),
    .open_load_fault_bit(olb), .overvoltage_fault_bit(ovb), .undervoltage_fault_bit(uvb));

  // ==========================================================================
  // Access tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic s, input logic on, input logic [2:0] ls, input logic [2:0] dis);
    @(posedge sys_clk) {cw, cs, con, lsel, ovd, uvd, old} <= {1'b1, s, on, ls, dis};
    @(posedge sys_clk) cw <= 1'b0;
    cyc(2);
  endtask : wr

  task automatic rd(input logic s);
    @(posedge sys_clk) {sr, ss} <= {1'b1, s};
    @(posedge sys_clk) sr <= 1'b0;
    cyc(2);
  endtask : rd

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  task automatic results;
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // ==========================================================================
  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    results();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk) want <= 2'h2;
    wr(1'b0, 1'b1, 3'h5, 3'h0);
    cyc(4);
    `CHK({flag_n, drv, lthr[0]}, 6'h3D)
    @(posedge sys_clk) fse <= 1'b1;
    @(posedge sys_clk) fse <= 1'b0;
    cyc(2);
    `CHK({drv, lthr[0]}, 5'h18)
    done("config");
    @(posedge sys_clk) ov <= 1'b1;
    cyc(4);
    `CHK({flag_n, drv, ovb}, 4'h1)
    @(posedge sys_clk) ov <= 1'b0;
    cyc(4);
    `CHK({flag_n, drv, ovb}, 4'hF)
    rd(1'b0);
    `CHK({sw[1], ovb}, 2'h2)
    wr(1'b0, 1'b1, 3'h0, 3'h4);
    @(posedge sys_clk) ov <= 1'b1;
    cyc(4);
    `CHK({flag_n, drv, ovb}, 4'hE)
    @(posedge sys_clk) {ov, ch} <= {1'b0, 2'h2};
    done("overvoltage");
    cyc(4);
    @(posedge sys_clk) ch <= 2'h0;
    cyc(4);
    `CHK({flag_n, drv}, 3'h1)
    rd(1'b1);
    `CHK(sw[5], 1'b1)
    @(posedge sys_clk) reiss <= 2'h2;
    @(posedge sys_clk) reiss <= 2'h0;
    cyc(6);
    `CHK({flag_n, drv}, 3'h7)
    @(posedge sys_clk) cl <= 2'h1;
    cyc(400);
    `CHK(drv, 2'h3)
    cyc(200);
    `CHK({flag_n, drv}, 3'h2)
    @(posedge sys_clk) cl <= 2'h0;
    rd(1'b0);
    `CHK(sw[4], 1'b1)
    wr(1'b0, 1'b0, 3'h0, 3'h0);
    wr(1'b0, 1'b1, 3'h0, 3'h0);
    cyc(4);
    `CHK({flag_n, drv}, 3'h7)
    done("overcurrent");
    @(posedge sys_clk) uv <= 1'b1;
    cyc(4);
    `CHK({flag_n, drv, uvb}, 4'h1)
    @(posedge sys_clk) uv <= 1'b0;
    cyc(4);
    `CHK({flag_n, drv, uvb}, 4'h1)
    @(posedge sys_clk) want <= 2'h0;
    wr(1'b0, 1'b0, 3'h0, 3'h0);
    cyc(4);
    `CHK({flag_n, drv, uvb}, 4'h9)
    rd(1'b0);
    `CHK({sw[0], uvb}, 2'h2)
    @(posedge sys_clk) want <= 2'h2;
    wr(1'b0, 1'b1, 3'h0, 3'h2);
    @(posedge sys_clk) uv <= 1'b1;
    cyc(4);
    `CHK({flag_n, drv, uvb}, 4'hE)
    @(posedge sys_clk) bm <= 1'b1;
    cyc(4);
    `CHK(drv, 2'h0)
    @(posedge sys_clk) {uv, bm} <= 2'h0;
    wr(1'b0, 1'b0, 3'h0, 3'h0);
    done("undervoltage");
    @(posedge sys_clk) ot <= 2'h2;
    cyc(4);
    `CHK({drv[1], tfb[1], flag_n}, 3'h2)
    @(posedge sys_clk) ot <= 2'h0;
    cyc(4);
    `CHK({drv[1], tfb[1], flag_n}, 3'h7)
    rd(1'b1);
    `CHK({sw[2], tfb[1]}, 2'h2)
    @(posedge sys_clk) {want, ot} <= {2'h0, 2'h1};
    cyc(4);
    `CHK(tfb, 2'h0)
    @(posedge sys_clk) {ot, ol, gl} <= {2'h0, 2'h2, 2'h2};
    cyc(4);
    `CHK({olb, flag_n}, 3'h4)
    rd(1'b1);
    `CHK(olb, 2'h2)
    @(posedge sys_clk) {ol, gl} <= 4'h0;
    cyc(4);
    `CHK(flag_n, 1'b1)
    rd(1'b1);
    `CHK({sw[3], olb}, 3'h4)
    wr(1'b1, 1'b0, 3'h3, 3'h1);
    @(posedge sys_clk) {ol, gl} <= 4'hA;
    cyc(4);
    `CHK({olb, flag_n, lthr[1]}, 6'h0B)
    done("thermal_open_load");
    @(posedge sys_clk) {want, spo} <= 3'h4;
    cyc(4);
    `CHK({drv, lthr[1]}, 5'h10)
    @(posedge sys_clk) spo <= 1'b1;
    done("supply_loss");
    cyc(2);
    @(posedge sys_clk) {hsel, bsel} <= 3'h5;
    wr(1'b1, 1'b0, 3'h0, 3'h0);
    `CHK(hthr, 2'h2)
    @(posedge sys_clk) cl <= 2'h2;
    cyc(1000);
    `CHK(drv, 2'h2)
    cyc(10);
    `CHK({flag_n, drv}, 3'h0)
    @(posedge sys_clk) cl <= 2'h0;
    rd(1'b1);
    `CHK(sw[5:4], 2'h1)
    @(posedge sys_clk) fse <= 1'b1;
    @(posedge sys_clk) fse <= 1'b0;
    cyc(2);
    `CHK(hthr, 2'h0)
    done("blanking_code");
    @(posedge sys_clk) arst_n <= 1'b0;
    cyc(1);
    `CHK({flag_n, drv, hthr, olb}, 7'h40)
    @(posedge sys_clk) arst_n <= 1'b1;
    done("reset");
    results();
  end

endmodule : tb_sfp_switch_fault_protection

`default_nettype wire
